// ===== strap_cfg.svh
// Constants for the strap option latch: offsets, reset values, fields, timing
`ifndef STRAP_CFG_SVH
`define STRAP_CFG_SVH

// Register byte offsets on the AHB-Lite slave
`define OFS_ADDR   12'h000
`define OFS_MODE   12'h004
`define OFS_ADV    12'h008
`define OFS_STRAP  12'h00c
`define OFS_IND    12'h010

// Strap pin indices on the shared pad vector
`define PIN_ADDR_MSB 4
`define PIN_CAP_LO   5
`define PIN_CAP_HI   6
`define PIN_AUTONEG_ENABLE_STRAP    7
`define NUM_PINS     8

// Internal pull levels: address bit 0 up, bits 4..1 down, capability and autoneg straps up
`define STRAP_PULL   8'he1

// Reset values, matching an unstrapped board
`define ADDR_RST     5'h01
`define AUTONEG_ENABLE_STRAP_RST    1'b1
`define CAP_RST      2'h3
`define IND_RST      8'h00
`define SPD_RST      1'b1
`define FDX_RST      1'b1
`define ISO_RST      1'b0
`define ADV_RST      4'hf

// Strapped address that selects isolation
`define ISO_ADDR     5'h00

// Advertisement codes, bits {100F,100H,10F,10H}
`define ADV_NONE     4'h0
`define ADV_10_HF    4'h3
`define ADV_100_HF   4'hc
`define ADV_HALF     4'h5
`define ADV_ALL      4'hf

// MODE register fields
`define MODE_AN      0
`define MODE_SPD     1
`define MODE_FDX     2
`define MODE_ISO     3

// STRAP register fields
`define STR_AN       5
`define STR_CAP_LSB  6
`define STR_DONE     8

// Capability select codes
`define CAP_10H      2'h0
`define CAP_10F      2'h1
`define CAP_100H     2'h2
`define CAP_100F     2'h3

// Settle count; the sequencer spends this many cycles plus one after reset release before the straps are latched
`define STRAP_SETTLE_CYC 4'h4

`endif

// ===== strap_pkg.sv
// Types shared by the strap option latch
package strap_pkg;

  // Configuration captured from the strap pins
  typedef struct packed {
    logic       autoneg_en;
    logic [1:0] cap_sel;
    logic [4:0] mgmt_addr;
  } strap_cfg_s;

  // Operating mode derived from the straps, software may adjust it
  typedef struct packed {
    logic isolate;
    logic full_duplex;
    logic speed100;
    logic autoneg_en;
  } op_mode_s;

  // Sequencer from reset release to normal pin use
  typedef enum logic [2:0] {
    ST_SETTLE = 3'b001,
    ST_LATCH  = 3'b010,
    ST_RUN    = 3'b100
  } strap_state_e;

endpackage

// ===== strap_pin_cell.sv
// One dual-purpose pad: strap input synchroniser and functional output driver
`timescale 1ns/100ps

module strap_pin_cell #(
  parameter logic PULL_LEVEL = 1'b0
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Pad side
  input  wire logic pad_in,
  output logic      pad_out,
  output logic      pad_oe_n,
  // Core side
  input  wire logic drive_en,
  input  wire logic drive_val,
  output logic      level
);

  logic sync1_ff;
  logic sync2_ff;
  logic out_ff;
  logic oe_n_ff;

  // Two-stage synchroniser, idles at the pull level while in reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_ff <= PULL_LEVEL;
      sync2_ff <= PULL_LEVEL;
    end else begin
      sync1_ff <= pad_in;
      sync2_ff <= sync1_ff;
    end
  end

  // Output driver stays released until the core hands the pin over
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_ff  <= 1'b0;
      oe_n_ff <= 1'b1;
    end else begin
      out_ff  <= drive_val;
      oe_n_ff <= ~drive_en;
    end
  end

  assign level    = sync2_ff;
  assign pad_out  = out_ff;
  assign pad_oe_n = oe_n_ff;

endmodule

// ===== strap_option_latch.sv
// Strap option latch with AHB-Lite register access
//
// Function
// - Sample strap pins around reset and configure the device from them.
// - Capture five-bit management address from five straps into address register.
// - Any strapped address zero through thirty-one is accepted as valid.
// - Strapped address zero puts the interface into isolate mode.
// - Software writing address zero never sets isolate mode.
// - Unstrapped address bit 0 reads as one through its pull-up.
// - Unstrapped address bits 4..1 read as zero; default address is one.
// - Autoneg strap high advertises the code for the capability straps (10F strap gives 100F and 100H); low forces the selected mode.
// - Pins become outputs only after reset release; captured values are kept.
// - Every reset assertion resamples straps and reinitialises all registers.
//
// Added by the designer: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps

`include "strap_cfg.svh"

module strap_option_latch
  import strap_pkg::*;
#(
  parameter int NUM_PINS   = `NUM_PINS,
  parameter int SETTLE_CYC = `STRAP_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  // Shared strap and functional pads
  input  wire logic [NUM_PINS-1:0] pad_in,
  output logic [NUM_PINS-1:0]      pad_out,
  output logic [NUM_PINS-1:0]      pad_oe_n,
  // Configuration to the rest of the device
  output strap_cfg_s               strap_cfg,
  output op_mode_s                 op_mode,
  output logic [4:0]               mgmt_addr,
  output logic [3:0]               adv_cap,
  output logic                     strap_done
);

  // Sequencer and captured state
  strap_state_e state_ff;
  strap_state_e nxt_state;
  logic [3:0]   settle_ff;
  strap_cfg_s   strap_ff;
  logic [4:0]   addr_ff;
  op_mode_s     mode_ff;
  logic [3:0]   adv_ff;
  logic [7:0]   ind_ff;
  logic [31:0]  rdata_ff;
  logic         wr_pend_ff;
  logic [11:0]  wr_ofs_ff;

  // Synchronised pad levels and decoded strap view
  logic [NUM_PINS-1:0] level;
  strap_cfg_s          strap_now;
  op_mode_s            strap_mode;
  logic [3:0]          strap_adv;
  logic                addr_phase;
  logic [31:0]         rd_mux;
  logic [7:0]          drive_val;

  // Write strobes decoded in the data phase
  logic                wr_addr;
  logic                wr_mode;
  logic                wr_ind;

  // Internal pull level of every pad, seen by its synchroniser in reset
  localparam logic [NUM_PINS-1:0] PULL_VEC = `STRAP_PULL;

  // One cell per shared pad; outputs enabled only in normal running
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_pin
      strap_pin_cell #(
        .PULL_LEVEL (PULL_VEC[gi])
      ) u_cell (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .pad_in    (pad_in[gi]),
        .pad_out   (pad_out[gi]),
        .pad_oe_n  (pad_oe_n[gi]),
        .drive_en  (state_ff == ST_RUN),
        .drive_val (drive_val[gi]),
        .level     (level[gi])
      );
    end
  endgenerate

  // Functional levels driven on the pads once running
  assign drive_val = ind_ff;

  // Strap fields as seen on the synchronised pads
  always_comb begin
    strap_now.mgmt_addr  = level[`PIN_ADDR_MSB:0];
    strap_now.cap_sel    = {level[`PIN_CAP_HI], level[`PIN_CAP_LO]};
    strap_now.autoneg_en = level[`PIN_AUTONEG_ENABLE_STRAP];
  end

  // Decode the capability straps into forced mode and advertisement
  always_comb begin
    strap_mode.autoneg_en  = strap_now.autoneg_en;
    strap_mode.isolate     = (strap_now.mgmt_addr == `ISO_ADDR);
    strap_mode.speed100    = 1'b0;
    strap_mode.full_duplex = 1'b0;
    strap_adv              = `ADV_NONE;
    case (strap_now.cap_sel)
      `CAP_10H: begin
        strap_adv = `ADV_10_HF;
      end
      `CAP_10F: begin
        strap_mode.full_duplex = 1'b1;
        strap_adv              = `ADV_100_HF;
      end
      `CAP_100H: begin
        strap_mode.speed100 = 1'b1;
        strap_adv           = `ADV_HALF;
      end
      default: begin
        strap_mode.speed100    = 1'b1;
        strap_mode.full_duplex = 1'b1;
        strap_adv              = `ADV_ALL;
      end
    endcase
    if (!strap_now.autoneg_en) begin
      strap_adv = `ADV_NONE;
    end
  end

  // Next state of the reset-release sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_SETTLE: begin
        if (settle_ff == SETTLE_CYC[3:0]) begin
          nxt_state = ST_LATCH;
        end
      end
      ST_LATCH: begin
        nxt_state = ST_RUN;
      end
      ST_RUN: begin
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_SETTLE;
      end
    endcase
  end

  // Sequencer restarts on every reset so straps are resampled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= ST_SETTLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Settle counter lets the synchronisers fill with pad levels
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_ff <= 4'h0;
    end else if (state_ff == ST_SETTLE) begin
      settle_ff <= settle_ff + 4'h1;
    end
  end

  // Captured strap snapshot, taken once and then held
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_ff.mgmt_addr  <= `ADDR_RST;
      strap_ff.cap_sel    <= `CAP_RST;
      strap_ff.autoneg_en <= `AUTONEG_ENABLE_STRAP_RST;
    end else if (state_ff == ST_LATCH) begin
      strap_ff <= strap_now;
    end
  end

  // AHB-Lite address phase qualifier
  assign addr_phase = hsel & htrans[1] & hready;

  // Write is held over to the data phase when hwdata is valid
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_ofs_ff  <= 12'h000;
    end else begin
      wr_pend_ff <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_ofs_ff <= haddr[11:0];
      end
    end
  end

  // Data-phase write strobes, one per writable register
  assign wr_addr = wr_pend_ff & (wr_ofs_ff == `OFS_ADDR);
  assign wr_mode = wr_pend_ff & (wr_ofs_ff == `OFS_MODE);
  assign wr_ind  = wr_pend_ff & (wr_ofs_ff == `OFS_IND);

  // Management address register: strap load, then software may rewrite
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_ff <= `ADDR_RST;
    end else if (state_ff == ST_LATCH) begin
      addr_ff <= strap_now.mgmt_addr;
    end else if (wr_addr) begin
      addr_ff <= hwdata[4:0];
    end
  end

  // Operating mode: loaded from straps, isolate can only be cleared by software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_ff.autoneg_en  <= `AUTONEG_ENABLE_STRAP_RST;
      mode_ff.speed100    <= `SPD_RST;
      mode_ff.full_duplex <= `FDX_RST;
      mode_ff.isolate     <= `ISO_RST;
    end else if (state_ff == ST_LATCH) begin
      mode_ff <= strap_mode;
    end else if (wr_mode) begin
      mode_ff.autoneg_en  <= hwdata[`MODE_AN];
      mode_ff.speed100    <= hwdata[`MODE_SPD];
      mode_ff.full_duplex <= hwdata[`MODE_FDX];
      mode_ff.isolate     <= mode_ff.isolate & hwdata[`MODE_ISO];
    end
  end

  // Advertised capability, loaded once from the straps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adv_ff <= `ADV_RST;
    end else if (state_ff == ST_LATCH) begin
      adv_ff <= strap_adv;
    end
  end

  // Functional output levels for the shared pads
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ind_ff <= `IND_RST;
    end else if (wr_ind) begin
      ind_ff <= hwdata[7:0];
    end
  end

  // Read multiplexer, unmapped offsets read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (haddr[11:0] == `OFS_ADDR) begin
      rd_mux[4:0] = addr_ff;
    end else if (haddr[11:0] == `OFS_MODE) begin
      rd_mux[`MODE_AN]  = mode_ff.autoneg_en;
      rd_mux[`MODE_SPD] = mode_ff.speed100;
      rd_mux[`MODE_FDX] = mode_ff.full_duplex;
      rd_mux[`MODE_ISO] = mode_ff.isolate;
    end else if (haddr[11:0] == `OFS_ADV) begin
      rd_mux[3:0] = adv_ff;
    end else if (haddr[11:0] == `OFS_STRAP) begin
      rd_mux[4:0]                       = strap_ff.mgmt_addr;
      rd_mux[`STR_AN]                   = strap_ff.autoneg_en;
      rd_mux[`STR_CAP_LSB+1:`STR_CAP_LSB] = strap_ff.cap_sel;
      rd_mux[`STR_DONE]                 = (state_ff == ST_RUN);
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  // Read data registered at the address phase, valid in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_ff <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      rdata_ff <= rd_mux;
    end
  end

  // A read straight after a write waits one cycle, so that its data,
  // taken in the address phase, already shows the written value
  assign hreadyout = ~(wr_pend_ff & hsel & htrans[1] & ~hwrite);
  // Response is always OKAY
  assign hresp     = 1'b0;
  assign hrdata    = rdata_ff;

  // Configuration outputs
  assign strap_cfg  = strap_ff;
  assign op_mode    = mode_ff;
  assign mgmt_addr  = addr_ff;
  assign adv_cap    = adv_ff;
  assign strap_done = (state_ff == ST_RUN);

endmodule

// ===== strap_pull_model.sv
// Board strap resistors and pad wire resolution
`timescale 1ns/100ps

`include "strap_cfg.svh"

module strap_pull_model #(
  parameter int NUM_PINS = 8
) (
  // Device drive
  input  wire logic [NUM_PINS-1:0] pad_out,
  input  wire logic [NUM_PINS-1:0] pad_oe_n,
  // Board resistors
  input  wire logic [NUM_PINS-1:0] strap_val,
  input  wire logic [NUM_PINS-1:0] strap_fit,
  // Resolved level
  output logic      [NUM_PINS-1:0] pad_in
);
  logic [NUM_PINS-1:0] pull_lvl;

  // Weak internal pulls where no resistor is fitted
  assign pull_lvl = `STRAP_PULL;
  // Device drive wins, then a fitted resistor, then the weak pull
  assign pad_in = (pad_out & ~pad_oe_n) | (pad_oe_n & strap_fit & strap_val)
                | (pad_oe_n & ~strap_fit & pull_lvl);
endmodule

// ===== strap_option_latch_monitor.sv
// Assertion checker for the strap option latch
`timescale 1ns/100ps

module strap_option_latch_monitor
  import strap_pkg::*;
#(
  parameter int NUM_PINS   = 8,
  parameter int SETTLE_CYC = 4
) (
  // Clock and reset
  input wire logic                hclk,
  input wire logic                hresetn,
  // Pads and configuration
  input wire logic [NUM_PINS-1:0] pad_oe_n,
  input wire strap_cfg_s          strap_cfg,
  input wire op_mode_s            op_mode,
  input wire logic [4:0]          mgmt_addr,
  input wire logic [3:0]          adv_cap,
  input wire logic                strap_done
);
  logic [4:0] cyc_ff;
  logic [3:0] adv_exp;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Cycles since reset release, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_ff <= 5'h00;
    end else if (cyc_ff != 5'h1f) begin
      cyc_ff <= cyc_ff + 5'h01;
    end
  end

  // Advertisement expected from the captured straps
  assign adv_exp = !strap_cfg.autoneg_en ? 4'h0 : strap_cfg.cap_sel == 2'h0 ? 4'h3
                 : strap_cfg.cap_sel == 2'h1 ? 4'hc : strap_cfg.cap_sel == 2'h2 ? 4'h5 : 4'hf;

  done_time_a: assert property (strap_done == (cyc_ff >= SETTLE_CYC + 2))
    else $error("strap_done at wrong cycle");
  oe_held_a: assert property (!strap_done |-> &pad_oe_n)
    else $error("pad driven before capture");
  oe_drive_a: assert property ($rose(strap_done) |-> &pad_oe_n ##1 pad_oe_n == '0)
    else $error("pad drive not enabled after capture");
  addr_load_a: assert property ($rose(strap_done) |-> mgmt_addr == strap_cfg.mgmt_addr)
    else $error("address not loaded from straps");
  iso_strap_a: assert property ($rose(strap_done) |-> op_mode.isolate == !strap_cfg.mgmt_addr)
    else $error("isolate does not follow strapped address");
  iso_sw_a: assert property (strap_done && $past(strap_done) |-> !$rose(op_mode.isolate))
    else $error("isolate set after capture");
  mode_load_a: assert property ($rose(strap_done) |->
    op_mode.speed100 == strap_cfg.cap_sel[1] && op_mode.full_duplex == strap_cfg.cap_sel[0]
    && op_mode.autoneg_en == strap_cfg.autoneg_en)
    else $error("mode not loaded from straps");
  adv_load_a: assert property ($rose(strap_done) |-> adv_cap == adv_exp)
    else $error("advertisement wrong");
  cfg_hold_a: assert property (strap_done && $past(strap_done) |-> $stable(strap_cfg))
    else $error("captured straps changed");

  // Main scenarios
  cov_iso_c: cover property ($rose(strap_done) && strap_cfg.mgmt_addr == 5'h00);
  cov_forced_c: cover property ($rose(strap_done) && !strap_cfg.autoneg_en);
  cov_clear_c: cover property (strap_done && $fell(op_mode.isolate));
endmodule

bind strap_option_latch strap_option_latch_monitor #(
  .NUM_PINS  (NUM_PINS),
  .SETTLE_CYC(SETTLE_CYC)
) u_mon (
  .hclk(hclk), .hresetn(hresetn), .pad_oe_n(pad_oe_n), .strap_cfg(strap_cfg),
  .op_mode(op_mode), .mgmt_addr(mgmt_addr), .adv_cap(adv_cap), .strap_done(strap_done)
);

// ===== strap_option_latch_tb.sv
// Self-checking bench for the strap option latch
`timescale 1ns/100ps

`include "strap_cfg.svh"

module strap_option_latch_tb
  import strap_pkg::*;
;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        rd_dp = 1'b0;
  logic        done_d = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [7:0]  strap_val = 8'h00, strap_fit = 8'h00, pad_in, pad_out, pad_oe_n;
  logic        hreadyout, hresp, strap_done;
  logic [4:0]  mgmt_addr;
  logic [3:0]  adv_cap;
  strap_cfg_s  strap_cfg;
  op_mode_s    op_mode;
  int          n_errors = 0, checks = 0, cyc = 0;
  logic [31:0] exp_q[$], cfg_q[$];
  string       nm_q[$];

  // Clock
  always #2.5 hclk = ~hclk;

  strap_option_latch dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .strap_cfg(strap_cfg), .op_mode(op_mode),
    .mgmt_addr(mgmt_addr), .adv_cap(adv_cap), .strap_done(strap_done)
  );

  strap_pull_model u_pull (
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .strap_val(strap_val),
    .strap_fit(strap_fit), .pad_in(pad_in)
  );

  task automatic results();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One single AHB-Lite transfer; a read notes its expected data
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d, input string nm);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {20'h0, a};
    hwrite <= w;
    if (!w) begin
      exp_q.push_back(d);
      nm_q.push_back(nm);
    end
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    rd_dp  <= !w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_dp  <= 1'b0;
  endtask

  // Strap, reset, then check capture, software access and pad use
  task automatic run_case(input logic [7:0] v, input logic [7:0] fit);
    logic [7:0]  r;
    logic [3:0]  adv;
    logic [31:0] mode, ind, st;
    r    = (v & fit) | (`STRAP_PULL & ~fit);
    adv  = !r[7] ? 4'h0 : r[6:5] == 2'h0 ? 4'h3 : r[6:5] == 2'h1 ? 4'hc
         : r[6:5] == 2'h2 ? 4'h5 : 4'hf;
    mode = {28'h0, r[4:0] == 5'h00, r[5], r[6], r[7]};
    st   = {23'h0, 1'b1, r[6:5], r[7], r[4:0]};
    ind  = $urandom & 32'hff;
    cfg_q.push_back({11'h0, adv, mode[3:0], r, r[4:0]});
    @(posedge hclk);
    hresetn   <= 1'b0;
    strap_val <= v;
    strap_fit <= fit;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    while (strap_done !== 1'b1) @(posedge hclk);
    ahb(1'b0, `OFS_ADDR, {27'h0, r[4:0]}, "addr");
    ahb(1'b0, `OFS_STRAP, st, "strap");
    ahb(1'b1, `OFS_ADDR, 32'h0, "");
    ahb(1'b1, `OFS_MODE, mode | 32'h8, "");
    ahb(1'b1, `OFS_ADV, 32'h0, "");
    ahb(1'b1, `OFS_IND, ind, "");
    strap_val <= ~v;
    ahb(1'b0, `OFS_ADDR, 32'h0, "addr");
    ahb(1'b0, `OFS_MODE, mode, "mode");
    ahb(1'b0, 12'h014, 32'h0, "unmapped");
    ahb(1'b0, `OFS_ADV, {28'h0, adv}, "adv");
    ahb(1'b0, `OFS_STRAP, st, "strap");
    cmp("pads", ind, {24'h0, pad_out});
    ahb(1'b1, `OFS_MODE, mode & 32'h7, "");
    ahb(1'b0, `OFS_MODE, mode & 32'h7, "mode");
  endtask

  // Compare read data and captured configuration as they appear
  always @(posedge hclk) begin
    if (rd_dp && hreadyout === 1'b1 && exp_q.size() > 0) begin
      cmp(nm_q.pop_front(), exp_q.pop_front(), hrdata);
    end
    if (strap_done === 1'b1 && done_d !== 1'b1 && cfg_q.size() > 0) begin
      cmp("config", cfg_q.pop_front(),
          {11'h0, adv_cap, op_mode, strap_cfg, mgmt_addr});
    end
    done_d = strap_done;
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      results();
    end
  end

  // Every strap code, boundary addresses, partial and absent resistors
  initial begin
    logic [7:0] v;
    void'($urandom(53326));
    for (int i = 0; i < 9; i++) begin
      v = {i[2:0], 5'($urandom)};
      if (i == 0) v[4:0] = 5'h00;
      if (i == 1) v[4:0] = 5'h1f;
      run_case(v, i == 8 ? 8'h00 : i == 7 ? 8'($urandom) : 8'hff);
      $display("case %0d done", i);
    end
    results();
  end
endmodule
